// File: core/xcvr_lane.sv
// one bit channel: two storage bits and the two registered pin drivers
`timescale 1ns/100ps
module xcvr_lane
   import xcvr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic a_in,
   input wire logic b_in,
   input wire logic a_capture,
   input wire logic b_capture,
   input wire logic drive_enable_n,
   input wire logic flow_select,
   input wire logic a_port_source_select,
   input wire logic b_port_source_select,
   output logic a_out,
   output logic a_oe_n,
   output logic b_out,
   output logic b_oe_n,
   output logic a_store,
   output logic b_store
);
   typedef struct packed {
      logic a_store;
      logic b_store;
      logic a_out;
      logic a_oe_n;
      logic b_out;
      logic b_oe_n;
   } lane_s;

   lane_s q;
   lane_s d;

   // ==========================================================
   // next state
   always_comb begin
      d = q;
      // capture ignores enable and flow select on purpose
      d.a_store = a_capture ? a_in : q.a_store;
      d.b_store = b_capture ? b_in : q.b_store;
      // only one side can ever be enabled, flow select decides which
      d.a_oe_n = drive_enable_n | flow_select;
      d.b_oe_n = drive_enable_n | ~flow_select;
      d.a_out = a_port_source_select ? ~q.b_store : b_in;
      d.b_out = b_port_source_select ? ~q.a_store : ~a_in;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.a_oe_n <= 1'b1;
         q.b_oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign a_out = q.a_out;
   assign a_oe_n = q.a_oe_n;
   assign b_out = q.b_out;
   assign b_oe_n = q.b_oe_n;
   assign a_store = q.a_store;
   assign b_store = q.b_store;

   // ==========================================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence drive_a_s;
      !drive_enable_n && !flow_select;
   endsequence
   sequence drive_b_s;
      !drive_enable_n && flow_select;
   endsequence

   chk_a_capture_load: assert property (a_capture |=> a_store == $past(a_in))
      else $error("a store missed a capture");
   chk_b_capture_load: assert property (b_capture |=> b_store == $past(b_in))
      else $error("b store missed a capture");
   chk_store_hold: assert property (!a_capture && !b_capture |=> $stable(a_store) && $stable(b_store))
      else $error("store changed without capture");
   chk_a_side_drive: assert property (drive_a_s |=> !a_oe_n && b_oe_n)
      else $error("a side not driven alone");
   chk_isolation: assert property (drive_enable_n |=> a_oe_n && b_oe_n)
      else $error("bus driven while disabled");
   chk_single_bus: assert property (a_oe_n || b_oe_n)
      else $error("both buses driven");
   chk_live_to_a: assert property (drive_a_s ##0 !a_port_source_select |=> a_out == $past(b_in))
      else $error("live b not on a");
   chk_stored_to_a: assert property (drive_a_s ##0 a_port_source_select |=> a_out == !$past(b_store))
      else $error("stored b not on a");
   chk_live_to_b: assert property (drive_b_s ##0 !b_port_source_select |=> b_out == !$past(a_in))
      else $error("live a not on b");
   chk_stored_to_b: assert property (drive_b_s ##0 b_port_source_select |=> b_out == !$past(a_store))
      else $error("stored a not on b");
   chk_store_while_drive: assert property (drive_a_s ##0 b_capture |=> !a_oe_n && b_store == $past(b_in))
      else $error("undriven b not stored");
endmodule // xcvr_lane

// File: core/xcvr_pkg.sv
// constants and types shared by the bus transceiver register block, inverting except on the live b to a path
package xcvr_pkg;
   // ==========================================================
   // datapath
   localparam int unsigned LANES = 8;
   localparam int unsigned AXI_AW = 4;
   // ==========================================================
   // register map, byte addresses
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] STORE_OFFSET = 4'h4;
   localparam logic [3:0] LIVE_OFFSET = 4'h8;
   // ==========================================================
   // control register fields
   localparam int unsigned CTRL_W = 4;
   localparam int unsigned CTRL_DRIVE_N_BIT = 0;
   localparam int unsigned CTRL_FLOW_BIT = 1;
   localparam int unsigned CTRL_BSRC_BIT = 2;
   localparam int unsigned CTRL_ASRC_BIT = 3;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h1;
   // ==========================================================
   // store and live register fields
   localparam int unsigned A_FIELD_LSB = 0;
   localparam int unsigned B_FIELD_LSB = 8;
   // ==========================================================
   // axi answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_BRESP = 3'h2,
      ST_RRESP = 3'h4
   } axi_state_e;
endpackage

// File: core/xcvr_top.sv
// top of the bus transceiver register, inverting except on the live b to a path, with its axi4-lite control slave
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module xcvr_top
   import xcvr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic a_side_capture_clock,
   input wire logic b_side_capture_clock,
   input wire logic [LANES-1:0] port_a_data_in,
   output logic [LANES-1:0] port_a_data_out,
   output logic [LANES-1:0] port_a_data_oe_n,
   input wire logic [LANES-1:0] port_b_data_in,
   output logic [LANES-1:0] port_b_data_out,
   output logic [LANES-1:0] port_b_data_oe_n
);
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [2:0] a_clk_sync;
      logic [2:0] b_clk_sync;
      logic [LANES-1:0] a_data_s1;
      logic [LANES-1:0] a_data_s2;
      logic [LANES-1:0] b_data_s1;
      logic [LANES-1:0] b_data_s2;
      axi_state_e state;
      logic aw_got;
      logic w_got;
      logic [AXI_AW-1:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic arready;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } top_s;

   top_s q;
   top_s d;
   logic a_capture;
   logic b_capture;
   logic [LANES-1:0] a_store;
   logic [LANES-1:0] b_store;
   logic [AXI_AW-1:0] rd_word;
   logic [AXI_AW-1:0] wr_word;

   // ==========================================================
   // capture edges, taken from the second and third sync stages only
   assign a_capture = q.a_clk_sync[1] & ~q.a_clk_sync[2];
   assign b_capture = q.b_clk_sync[1] & ~q.b_clk_sync[2];
   assign rd_word = {s_axi_araddr[AXI_AW-1:2], 2'h0};
   assign wr_word = {q.waddr[AXI_AW-1:2], 2'h0};

   // ==========================================================
   // next state
   always_comb begin
      d = q;
      // pins come from outside aclk, two flops before anything reads them
      d.a_clk_sync = {q.a_clk_sync[1:0], a_side_capture_clock};
      d.b_clk_sync = {q.b_clk_sync[1:0], b_side_capture_clock};
      d.a_data_s1 = port_a_data_in;
      d.a_data_s2 = q.a_data_s1;
      d.b_data_s1 = port_b_data_in;
      d.b_data_s2 = q.b_data_s1;

      if (s_axi_awvalid && q.awready) begin
         d.aw_got = 1'b1;
         d.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end

      case (q.state)
         ST_IDLE: begin
            // a read taken in the same cycle as a write's address and data is served first
            if (s_axi_arvalid && q.arready) begin
               d.state = ST_RRESP;
               d.rvalid = 1'b1;
               d.rresp = RESP_OKAY;
               d.rdata = '0;
               if (rd_word == CTRL_OFFSET) begin
                  d.rdata[CTRL_W-1:0] = q.ctrl;
               end else if (rd_word == STORE_OFFSET) begin
                  d.rdata[A_FIELD_LSB +: LANES] = a_store;
                  d.rdata[B_FIELD_LSB +: LANES] = b_store;
               end else if (rd_word == LIVE_OFFSET) begin
                  d.rdata[A_FIELD_LSB +: LANES] = q.a_data_s2;
                  d.rdata[B_FIELD_LSB +: LANES] = q.b_data_s2;
               end else begin
                  d.rresp = RESP_DECERR;
               end
            end else if (q.aw_got && q.w_got) begin
               d.state = ST_BRESP;
               d.bvalid = 1'b1;
               d.aw_got = 1'b0;
               d.w_got = 1'b0;
               d.bresp = RESP_OKAY;
               if (wr_word == CTRL_OFFSET) begin
                  if (q.wstrb[0]) begin
                     d.ctrl = q.wdata[CTRL_W-1:0];
                  end
               end else if (wr_word == STORE_OFFSET || wr_word == LIVE_OFFSET) begin
                  d.bresp = RESP_SLVERR;
               end else begin
                  d.bresp = RESP_DECERR;
               end
            end
         end
         ST_BRESP: begin
            if (s_axi_bready) begin
               d.bvalid = 1'b0;
               d.state = ST_IDLE;
            end
         end
         ST_RRESP: begin
            if (s_axi_rready) begin
               d.rvalid = 1'b0;
               d.state = ST_IDLE;
            end
         end
         default: begin
            d.state = ST_IDLE;
         end
      endcase

      // readies follow the next state so they come straight from flops
      d.awready = (d.state == ST_IDLE) && !d.aw_got;
      d.wready = (d.state == ST_IDLE) && !d.w_got;
      d.arready = (d.state == ST_IDLE) && !d.aw_got && !d.w_got;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.ctrl <= CTRL_RESET;
         q.state <= ST_IDLE;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_arready = q.arready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;

   // ==========================================================
   // eight identical lanes on shared controls
   // capturing one side leaves the other side's drive purely to the controls
   genvar i;
   generate
      for (i = 0; i < LANES; i++) begin : g_lane
         xcvr_lane u_lane (
            .aclk(aclk),
            .aresetn(aresetn),
            .a_in(q.a_data_s2[i]),
            .b_in(q.b_data_s2[i]),
            .a_capture(a_capture),
            .b_capture(b_capture),
            .drive_enable_n(q.ctrl[CTRL_DRIVE_N_BIT]),
            .flow_select(q.ctrl[CTRL_FLOW_BIT]),
            .a_port_source_select(q.ctrl[CTRL_ASRC_BIT]),
            .b_port_source_select(q.ctrl[CTRL_BSRC_BIT]),
            .a_out(port_a_data_out[i]),
            .a_oe_n(port_a_data_oe_n[i]),
            .b_out(port_b_data_out[i]),
            .b_oe_n(port_b_data_oe_n[i]),
            .a_store(a_store[i]),
            .b_store(b_store[i])
         );
      end
   endgenerate

   // ==========================================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence a_edge_s;
      !q.a_clk_sync[1] ##1 q.a_clk_sync[1];
   endsequence

   chk_quiet_boot: assert property (q.ctrl[CTRL_DRIVE_N_BIT] |=> (&port_a_data_oe_n) && (&port_b_data_oe_n))
      else $error("bus driven before enable");
   chk_edge_capture: assert property (a_edge_s |=> a_store == $past(q.a_data_s2))
      else $error("a edge not captured");
   chk_ungated_capture: assert property (b_capture && q.ctrl[CTRL_DRIVE_N_BIT] |=> b_store == $past(q.b_data_s2))
      else $error("capture gated by enable");
   chk_lanes_agree: assert property ((&port_a_data_oe_n) || !(|port_a_data_oe_n))
      else $error("lanes disagree on enable");
   chk_opposite_quiet: assert property (a_capture && !q.ctrl[CTRL_DRIVE_N_BIT] && q.ctrl[CTRL_FLOW_BIT] |=> (&port_a_data_oe_n) && !(|port_b_data_oe_n))
      else $error("a capture changed drive state");
endmodule // xcvr_top

// File: testbench/bus_partner.sv
// far-side model: the two parallel buses that face the transceiver
`timescale 1ns/100ps
module bus_partner
   import xcvr_pkg::*;
(
   input wire logic [LANES-1:0] a_val,
   input wire logic [LANES-1:0] b_val,
   input wire logic [LANES-1:0] a_out,
   input wire logic [LANES-1:0] a_oe_n,
   input wire logic [LANES-1:0] b_out,
   input wire logic [LANES-1:0] b_oe_n,
   output logic [LANES-1:0] a_wire,
   output logic [LANES-1:0] b_wire
);
   // ==========================================================
   // wire resolution per lane
   // the far side lets go of every lane the device drives, so no lane ever fights
   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         a_wire[i] = a_oe_n[i] ? a_val[i] : a_out[i];
         b_wire[i] = b_oe_n[i] ? b_val[i] : b_out[i];
      end
   end
endmodule // bus_partner

// File: testbench/inverting_bus_transceiver_register_tb.sv
// self-checking bench for the transceiver register with its control slave
`timescale 1ns/100ps
module inverting_bus_transceiver_register_tb;
   import xcvr_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
   logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp, cp;
   logic a_side_capture_clock = 1'h0, b_side_capture_clock = 1'h0;
   logic [7:0] port_a_data_in, port_a_data_out, port_a_data_oe_n;
   logic [7:0] port_b_data_in, port_b_data_out, port_b_data_oe_n;
   logic [7:0] pa = '0, pb = '0, sa, sb, wa, wb;
   logic [3:0] ctl;
   int err_total = 0, comparisons = 0, seed;

   always #50 aclk = ~aclk;

   xcvr_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .a_side_capture_clock, .b_side_capture_clock, .port_a_data_in,
      .port_a_data_out, .port_a_data_oe_n, .port_b_data_in, .port_b_data_out,
      .port_b_data_oe_n);
   bus_partner u_bus (.a_val(pa), .b_val(pb), .a_out(port_a_data_out),
      .a_oe_n(port_a_data_oe_n), .b_out(port_b_data_out), .b_oe_n(port_b_data_oe_n),
      .a_wire(port_a_data_in), .b_wire(port_b_data_in));

   // ==========================================================
   // shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("errors=%0d comparisons=%0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // no local limit: a slave that never answers is caught by the watchdog
   task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d, input logic [3:0] st);
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask

   task automatic axi_rd(input logic [3:0] ad);
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask

   // model of the pins: which bus is driven and with what, from ctl and the stores
   task automatic compare_outs;
      logic drv_a, drv_b;
      drv_a = !ctl[0] && !ctl[1];
      drv_b = !ctl[0] && ctl[1];
      wa = drv_a ? (ctl[3] ? ~sb : pb) : pa;
      wb = drv_b ? (ctl[2] ? ~sa : ~pa) : pb;
      check(port_a_data_oe_n, drv_a ? 8'h00 : 8'hFF);
      check(port_b_data_oe_n, drv_b ? 8'h00 : 8'hFF);
      if (drv_a) check(port_a_data_out, wa);
      if (drv_b) check(port_b_data_out, wb);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      seed = $urandom(47);
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (3) @(posedge aclk);
      check({port_b_data_oe_n, port_a_data_oe_n}, 16'hFFFF);
      axi_rd(CTRL_OFFSET);
      check(rd, 32'(CTRL_RESET));
      check(resp, RESP_OKAY);
      sa = '0;
      sb = '0;
      for (int k = 0; k < 32; k++) begin
         ctl = k[3:0];
         pa <= 8'($urandom);
         pb <= 8'($urandom);
         axi_wr(CTRL_OFFSET, {28'h0, ctl}, 4'hF);
         check(resp, RESP_OKAY);
         repeat (8) @(posedge aclk);
         compare_outs();
         cp = 2'($urandom);
         a_side_capture_clock <= cp[0];
         b_side_capture_clock <= cp[1];
         if (cp[0]) sa = wa;
         if (cp[1]) sb = wb;
         repeat (3) @(posedge aclk);
         a_side_capture_clock <= 1'h0;
         b_side_capture_clock <= 1'h0;
         repeat (6) @(posedge aclk);
         compare_outs();
         axi_rd(STORE_OFFSET);
         check(rd, {16'h0, sb, sa});
         check(resp, RESP_OKAY);
         axi_rd(LIVE_OFFSET);
         check(rd, {16'h0, wb, wa});
      end
      axi_rd(4'hC);
      check(resp, RESP_DECERR);
      check(rd, 32'h0);
      axi_wr(STORE_OFFSET, 32'h0, 4'hF);
      check(resp, RESP_SLVERR);
      axi_wr(CTRL_OFFSET, 32'h0, 4'h0);
      check(resp, RESP_OKAY);
      axi_rd(CTRL_OFFSET);
      check(rd, {28'h0, ctl});
      report_and_stop();
   end

   // ==========================================================
   // watchdog: the loop needs under 3000 cycles
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      report_and_stop();
   end
endmodule // inverting_bus_transceiver_register_tb
